// File: rtl/oaa_piece.sv
// One bus piece: byte count and lane enables for the next transfer
`timescale 1ns/1ns
module oaa_piece
  import oaa_pkg::*;
(
  // Position
  input wire logic [2:0] lane,
  input wire logic [4:0] remain,
  input wire logic wide,
  // Piece
  output logic [3:0] cnt,
  output logic [7:0] be
);
  logic [3:0] gran;
  logic [3:0] room;
  logic [15:0] mask;
  always_comb begin
    // Granule sets where a split happens
    gran = wide ? GRAN_WIDE : GRAN_NARROW;
    room = gran - (wide ? {1'b0, lane} : {2'h0, lane[1:0]});
    cnt = ({1'b0, room} < remain) ? room : remain[3:0];
    mask = (16'h1 << cnt) - 16'h1;
    be = 8'(mask << lane);
  end
endmodule : oaa_piece

// File: rtl/oaa_pkg.sv
// Constants and types of the operand address and alignment unit
package oaa_pkg;
  localparam int CLK_MHZ = 25;
  localparam int ADDR_W = 64;
  localparam int GPR_N = 16;
  localparam int OPND_W = 128;
  localparam int BUS_W = 64;
  localparam logic [3:0] STACK_POINTER_REGISTER = 4'h4;
  localparam logic [3:0] PORT_INDEX_REGISTER = 4'h2;
  localparam logic [3:0] DQ_ALIGN_MASK = 4'hf;
  localparam logic [3:0] GRAN_NARROW = 4'h4;
  localparam logic [3:0] GRAN_WIDE = 4'h8;
  // Request kinds
  localparam logic [1:0] KIND_MEM = 2'h0;
  localparam logic [1:0] KIND_REL = 2'h1;
  localparam logic [1:0] KIND_IO = 2'h2;
  // Displacement width codes
  localparam logic [1:0] DISP_NONE = 2'h0;
  localparam logic [1:0] DISP_8 = 2'h1;
  localparam logic [1:0] DISP_16 = 2'h2;
  localparam logic [1:0] DISP_32 = 2'h3;
  // Size codes
  localparam logic [2:0] SZ_BYTE = 3'h0;
  localparam logic [2:0] SZ_WORD = 3'h1;
  localparam logic [2:0] SZ_DWORD = 3'h2;
  localparam logic [2:0] SZ_QWORD = 3'h3;
  localparam logic [2:0] SZ_DQWORD = 3'h4;
  // Segment selects
  localparam logic [2:0] SEG_CODE = 3'h0;
  localparam logic [2:0] DATA_SEGMENT_SEL = 3'h1;
  localparam logic [2:0] EXTRA_SEGMENT_SEL = 3'h2;
  localparam logic [2:0] SEG_STACK = 3'h3;
  localparam logic [2:0] AUX_SEGMENT_SEL_A = 3'h4;
  localparam logic [2:0] AUX_SEGMENT_SEL_B = 3'h5;
  typedef enum logic [2:0] {
    OAA_IDLE = 3'b001,
    OAA_ISSUE = 3'b010,
    OAA_DONE = 3'b100
  } oaa_state_e;
endpackage : oaa_pkg

// File: rtl/oaa_unit.sv
// Operand address generation and access splitting unit
`timescale 1ns/1ns
module oaa_unit
  import oaa_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register file write
  input wire logic gpr_wr_en,
  input wire logic [3:0] gpr_wr_sel,
  input wire logic [63:0] gpr_wr_data,
  // Request
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_write,
  input wire logic [2:0] req_size,
  input wire logic req_dq_strict,
  input wire logic req_ld_signed,
  input wire logic [31:0] req_disp,
  input wire logic [1:0] req_disp_width,
  input wire logic req_base_en,
  input wire logic [3:0] req_base_sel,
  input wire logic req_index_en,
  input wire logic [3:0] req_index_sel,
  input wire logic [1:0] req_scale,
  input wire logic [2:0] req_seg_sel,
  input wire logic [63:0] next_instruction_pointer,
  input wire logic [63:0] aux_base_a,
  input wire logic [63:0] aux_base_b,
  input wire logic req_io_imm_en,
  input wire logic [15:0] req_io_imm,
  input wire logic [127:0] req_wdata,
  output logic req_ready,
  // Load/store bus
  output logic bus_req,
  output logic bus_io,
  output logic bus_we,
  output logic [63:0] bus_addr,
  output logic [7:0] bus_be,
  output logic [63:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [63:0] bus_rdata,
  // Result
  output logic done,
  output logic general_protection_fault,
  output logic [63:0] lin_addr,
  output logic [127:0] rd_data
);
  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Register file and address sum
  // ****************************************
  logic [63:0] gpr_reg [GPR_N];
  oaa_state_e state_reg, state_next;
  logic [63:0] disp_ext, base_val, idx_val, seg_val, ea_next;
  logic index_ok, take, strict_bad;
  logic [4:0] size_bytes;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < GPR_N; i++) gpr_reg[i] <= 64'h0;
    end else if (ce && gpr_wr_en) begin
      gpr_reg[gpr_wr_sel] <= gpr_wr_data;
    end
  end

  always_comb begin
    case (req_disp_width)
      DISP_8: disp_ext = {{56{req_disp[7]}}, req_disp[7:0]};
      DISP_16: disp_ext = {{48{req_disp[15]}}, req_disp[15:0]};
      DISP_32: disp_ext = {{32{req_disp[31]}}, req_disp};
      default: disp_ext = 64'h0;
    endcase
    base_val = req_base_en ? gpr_reg[req_base_sel] : 64'h0;
    index_ok = req_index_en && (req_index_sel != STACK_POINTER_REGISTER);
    idx_val = index_ok ? (gpr_reg[req_index_sel] << req_scale) : 64'h0;
    if (req_seg_sel == AUX_SEGMENT_SEL_A) begin
      seg_val = aux_base_a;
    end else if (req_seg_sel == AUX_SEGMENT_SEL_B) begin
      seg_val = aux_base_b;
    end else begin
      seg_val = 64'h0;
    end
    // Carries out of bit 63 are dropped by the 64-bit target
    if (req_kind == KIND_REL) begin
      ea_next = next_instruction_pointer + {{32{req_disp[31]}}, req_disp};
    end else if (req_kind == KIND_IO) begin
      ea_next = {48'h0, req_io_imm_en ? req_io_imm
                 : gpr_reg[PORT_INDEX_REGISTER][15:0]};
    end else begin
      ea_next = base_val + idx_val + disp_ext + seg_val;
    end
    // I/O ports are at most 32 bits wide
    if (req_kind == KIND_IO && req_size > SZ_DWORD) begin
      size_bytes = 5'h4;
    end else begin
      size_bytes = 5'h1 << req_size;
    end
    take = ce && state_reg == OAA_IDLE && req_valid;
    strict_bad = req_size == SZ_DQWORD && req_dq_strict
                 && (ea_next[3:0] & DQ_ALIGN_MASK) != 4'h0;
  end

  // ****************************************
  // Piece sequencing
  // ****************************************
  logic [63:0] cur_addr_reg, pos_addr;
  logic [4:0] remain_reg, done_cnt_reg, pos_remain, pos_done;
  logic [3:0] cnt_reg, pc_cnt;
  logic [7:0] pc_be;
  logic wide_reg, pos_wide, last_ack;
  logic [127:0] wdata_reg, acc_reg, rd_piece, rd_mask;
  logic [2:0] size_reg;
  logic signed_reg, fault_pend_reg;

  assign last_ack = state_reg == OAA_ISSUE && bus_ack
                    && {1'b0, cnt_reg} == remain_reg;
  always_comb begin
    if (state_reg == OAA_IDLE) begin
      pos_addr = ea_next;
      pos_remain = size_bytes;
      pos_done = 5'h0;
      pos_wide = req_size >= SZ_QWORD && req_kind != KIND_IO;
    end else begin
      pos_addr = cur_addr_reg + 64'(cnt_reg);
      pos_remain = remain_reg - {1'b0, cnt_reg};
      pos_done = done_cnt_reg + {1'b0, cnt_reg};
      pos_wide = wide_reg;
    end
    rd_mask = (128'h1 << {cnt_reg, 3'h0}) - 128'h1;
    rd_piece = (128'(bus_rdata >> {cur_addr_reg[2:0], 3'h0}) & rd_mask)
               << {done_cnt_reg, 3'h0};
  end

  oaa_piece i_oaa_piece (
    .lane(pos_addr[2:0]),
    .remain(pos_remain),
    .wide(pos_wide),
    .cnt(pc_cnt),
    .be(pc_be)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OAA_IDLE: begin
        if (req_valid) state_next = strict_bad ? OAA_DONE : OAA_ISSUE;
      end
      OAA_ISSUE: begin
        if (last_ack) state_next = OAA_DONE;
      end
      OAA_DONE: state_next = OAA_IDLE;
      default: state_next = OAA_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= OAA_IDLE;
      req_ready <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      req_ready <= state_next == OAA_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_addr_reg <= 64'h0;
      remain_reg <= 5'h0;
      done_cnt_reg <= 5'h0;
      cnt_reg <= 4'h0;
      wide_reg <= 1'b0;
      bus_req <= 1'b0;
      bus_io <= 1'b0;
      bus_we <= 1'b0;
      bus_addr <= 64'h0;
      bus_be <= 8'h0;
      bus_wdata <= 64'h0;
    end else if (ce && ((take && !strict_bad)
                        || (state_reg == OAA_ISSUE && bus_ack))) begin
      cur_addr_reg <= pos_addr;
      remain_reg <= pos_remain;
      done_cnt_reg <= pos_done;
      cnt_reg <= pc_cnt;
      wide_reg <= pos_wide;
      bus_req <= !last_ack;
      if (take) bus_io <= req_kind == KIND_IO;
      if (take) bus_we <= req_write;
      bus_addr <= {pos_addr[63:3], 3'h0};
      bus_be <= pc_be;
      bus_wdata <= 64'(((take ? req_wdata : wdata_reg) >> {pos_done, 3'h0})
                       << {pos_addr[2:0], 3'h0});
    end
  end

  // ****************************************
  // Operand capture and result
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wdata_reg <= 128'h0;
      acc_reg <= 128'h0;
      size_reg <= SZ_BYTE;
      signed_reg <= 1'b0;
      fault_pend_reg <= 1'b0;
      lin_addr <= 64'h0;
    end else if (ce && take) begin
      wdata_reg <= req_wdata;
      acc_reg <= 128'h0;
      size_reg <= (req_kind == KIND_IO && req_size > SZ_DWORD)
                  ? SZ_DWORD : req_size;
      signed_reg <= req_ld_signed;
      fault_pend_reg <= strict_bad;
      lin_addr <= ea_next;
    end else if (ce && state_reg == OAA_ISSUE && bus_ack) begin
      acc_reg <= acc_reg | rd_piece;
    end
  end

  // Extension is applied once, so a split load is never seen half-built
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
      general_protection_fault <= 1'b0;
      rd_data <= 128'h0;
    end else if (ce) begin
      done <= state_reg == OAA_DONE;
      general_protection_fault <= state_reg == OAA_DONE && fault_pend_reg;
      if (state_reg == OAA_DONE) begin
        case (size_reg)
          SZ_BYTE: rd_data <= {{120{signed_reg & acc_reg[7]}},
                               acc_reg[7:0]};
          SZ_WORD: rd_data <= {{112{signed_reg & acc_reg[15]}},
                               acc_reg[15:0]};
          SZ_DWORD: rd_data <= {{96{signed_reg & acc_reg[31]}},
                                acc_reg[31:0]};
          SZ_QWORD: rd_data <= {{64{signed_reg & acc_reg[63]}},
                                acc_reg[63:0]};
          default: rd_data <= acc_reg;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_STRICT_FAULT: assert property (
    take && strict_bad |=> ##1 general_protection_fault)
    else $error("strict misaligned access did not fault");
  AST_FAULT_NO_BUS: assert property (
    take && strict_bad |=> !bus_req ##1 !bus_req)
    else $error("faulted access reached the bus");
  AST_ALIGNED_DWORD: assert property (
    take && req_kind == KIND_MEM && req_size == SZ_DWORD
    && ea_next[1:0] == 2'h0 |=> bus_req && cnt_reg == 4'h4)
    else $error("aligned dword not one piece");
  AST_SPLIT_WORD: assert property (
    take && req_kind == KIND_MEM && req_size == SZ_WORD
    && ea_next[1:0] == 2'h3 |=> bus_req && cnt_reg == 4'h1)
    else $error("boundary word not split");
  AST_LOW_LANE: assert property (
    take && !strict_bad |=> bus_be[lin_addr[2:0]])
    else $error("first piece misses the low byte lane");
  AST_REL_SUM: assert property (
    take && req_kind == KIND_REL |=> lin_addr == $past(
    next_instruction_pointer + {{32{req_disp[31]}}, req_disp}))
    else $error("relative address wrong");
  AST_SP_NO_INDEX: assert property (
    take && req_kind == KIND_MEM && !req_base_en && req_index_en
    && req_index_sel == STACK_POINTER_REGISTER
    && req_disp_width == DISP_NONE && req_seg_sel == DATA_SEGMENT_SEL
    |=> lin_addr == 64'h0)
    else $error("stack pointer used as index");
  AST_IO_PORT_REG: assert property (
    take && req_kind == KIND_IO && !req_io_imm_en
    |=> lin_addr == {48'h0, $past(gpr_reg[PORT_INDEX_REGISTER][15:0])})
    else $error("port address not from port index register");
  AST_DISP8_ONLY: assert property (
    take && req_kind == KIND_MEM && !req_base_en && !req_index_en
    && req_disp_width == DISP_8 && req_seg_sel == DATA_SEGMENT_SEL
    |=> lin_addr == {{56{$past(req_disp[7])}}, $past(req_disp[7:0])})
    else $error("8-bit displacement not sign-extended");
  COV_SPLIT: cover property (bus_req && bus_ack && !last_ack);
  COV_FAULT: cover property (general_protection_fault);
  COV_IO: cover property (bus_req && bus_io && bus_ack);
  COV_STORE: cover property (bus_req && bus_we && bus_ack);
endmodule : oaa_unit

// File: verification/oaa_bus_model.sv
// Load/store bus partner with a byte pattern memory
`timescale 1ns/1ns
module oaa_bus_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bus
  input wire logic bus_req,
  input wire logic [63:0] bus_addr,
  input wire logic bus_we,
  input wire logic [7:0] bus_be,
  input wire logic [63:0] bus_wdata,
  output logic bus_ack,
  output logic [63:0] bus_rdata,
  // Control and count
  input wire logic [3:0] lat,
  output logic [7:0] pieces,
  output logic [7:0] wbytes,
  output logic [7:0] wbad
);
  logic [3:0] wait_reg;
  // ****
  // Acknowledge after lat idle cycles
  // ****
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else if (bus_ack) begin
      bus_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else if (bus_req && wait_reg >= lat) begin
      bus_ack <= 1'b1;
    end else if (bus_req) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // Churns outside ack so stale data never matches
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_rdata <= 64'h0;
    end else if (bus_req && !bus_ack && wait_reg >= lat) begin
      for (int j = 0; j < 8; j++) begin
        bus_rdata[j*8+:8] <= (bus_addr[7:0] + 8'(j)) ^ 8'h5a;
      end
    end else begin
      bus_rdata <= ~bus_rdata;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pieces <= 8'h0;
    end else if (bus_req && bus_ack) begin
      pieces <= pieces + 8'h1;
    end
  end
  // ****
  // Store lanes against the byte pattern of their address
  // ****
  logic [7:0] lane_bad;
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      lane_bad[j] = bus_be[j]
        && (bus_wdata[j*8+:8] !== ((bus_addr[7:0] + 8'(j)) ^ 8'h5a));
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wbytes <= 8'h0;
      wbad <= 8'h0;
    end else if (bus_req && bus_ack && bus_we) begin
      wbytes <= wbytes + 8'($countones(bus_be));
      wbad <= wbad + 8'($countones(lane_bad));
    end
  end
endmodule : oaa_bus_model

// File: verification/tb_operand_address_alignment_unit.sv
// Self-checking bench of the operand address unit
`timescale 1ns/1ns
module tb_operand_address_alignment_unit;
  import oaa_pkg::*;
  // ****
  // Signals
  // ****
  logic mclk, sys_rst, ce, gpr_wr_en, req_valid, req_write;
  logic [3:0] gpr_wr_sel, req_base_sel, req_index_sel, lat;
  logic [63:0] gpr_wr_data, nip, aux_a, aux_b, bus_addr, bus_rdata;
  logic [1:0] req_kind, req_disp_width, req_scale;
  logic [2:0] req_size, req_seg_sel;
  logic req_dq_strict, req_ld_signed, req_base_en, req_index_en;
  logic [31:0] req_disp;
  logic req_io_imm_en, req_ready, bus_req, bus_ack, done, flt;
  logic [15:0] req_io_imm;
  logic [127:0] req_wdata, rd_data, g_rd;
  logic [63:0] lin_addr, g_lin;
  logic [7:0] pieces, g_pc;
  logic g_flt;
  logic bio, bwe;
  logic [7:0] b_be, wbytes, wbad;
  logic [63:0] b_wd;
  int n_fail = 0;
  int checked = 0;
  always #20 mclk = ~mclk;
  oaa_unit i_oaa_unit (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .gpr_wr_en(gpr_wr_en), .gpr_wr_sel(gpr_wr_sel),
    .gpr_wr_data(gpr_wr_data), .req_valid(req_valid),
    .req_kind(req_kind), .req_write(req_write), .req_size(req_size),
    .req_dq_strict(req_dq_strict), .req_ld_signed(req_ld_signed),
    .req_disp(req_disp), .req_disp_width(req_disp_width),
    .req_base_en(req_base_en), .req_base_sel(req_base_sel),
    .req_index_en(req_index_en), .req_index_sel(req_index_sel),
    .req_scale(req_scale), .req_seg_sel(req_seg_sel),
    .next_instruction_pointer(nip), .aux_base_a(aux_a),
    .aux_base_b(aux_b), .req_io_imm_en(req_io_imm_en),
    .req_io_imm(req_io_imm), .req_wdata(req_wdata),
    .req_ready(req_ready), .bus_req(bus_req), .bus_io(bio), .bus_we(bwe),
    .bus_addr(bus_addr), .bus_be(b_be), .bus_wdata(b_wd),
    .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .done(done), .general_protection_fault(flt),
    .lin_addr(lin_addr), .rd_data(rd_data));
  oaa_bus_model i_oaa_bus_model (.mclk(mclk), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_addr(bus_addr), .bus_we(bwe),
    .bus_be(b_be), .bus_wdata(b_wd), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .lat(lat), .pieces(pieces),
    .wbytes(wbytes), .wbad(wbad));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [127:0] ld(input logic [63:0] a,
    input logic [2:0] s, input logic g);
    logic [127:0] v;
    int n;
    v = '0;
    n = 1 << s;
    for (int i = 0; i < 16; i++)
      if (i < n) v[i*8+:8] = 8'(a + 64'(i)) ^ 8'h5a;
      else if (g) v[i*8+:8] = {8{v[n*8-1]}};
    return v;
  endfunction : ld
  task automatic wr(input logic [3:0] s, input logic [63:0] d);
    @(posedge mclk);
    gpr_wr_en <= 1'b1;
    gpr_wr_sel <= s;
    gpr_wr_data <= d;
    @(posedge mclk);
    gpr_wr_en <= 1'b0;
  endtask : wr
  task automatic go(input logic [1:0] k, input logic [2:0] sz,
    input logic [31:0] d, input logic [1:0] dw, input logic [4:0] b,
    input logic [4:0] x, input logic [1:0] sc, input logic [2:0] sg,
    input logic [2:0] fl);
    logic [7:0] p0;
    int n;
    n = 0;
    do @(negedge mclk); while (req_ready !== 1'b1);
    p0 = pieces;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_size <= sz;
    req_disp <= d;
    req_disp_width <= dw;
    {req_base_en, req_base_sel} <= b;
    {req_index_en, req_index_sel} <= x;
    req_scale <= sc;
    req_seg_sel <= sg;
    req_io_imm <= d[15:0];
    {req_dq_strict, req_ld_signed, req_io_imm_en} <= fl;
    @(posedge mclk);
    req_valid <= 1'b0;
    do begin
      @(negedge mclk);
      n++;
    end while (done !== 1'b1 && n < 60);
    if (n >= 60) n_fail++;
    g_lin = lin_addr;
    g_rd = rd_data;
    g_flt = flt;
    g_pc = pieces - p0;
  endtask : go
  // ****
  // Scenarios
  // ****
  task automatic t_ea();
    logic [63:0] e;
    logic [63:0] dext [4] = '{0, 64'hffffffffffffff80,
      64'hffffffffffff8080, 64'hffffffffffff8080};
    wr(4'h1, 64'h1000);
    wr(4'h3, 64'h20);
    wr(4'h4, 64'h100);
    wr(4'h5, 64'hfffffffffffffff0);
    for (int w = 0; w < 4; w++) begin
      go(KIND_MEM, SZ_DWORD, 32'hffff8080, w[1:0], 5'h11, 5'h13, w[1:0],
        DATA_SEGMENT_SEL, 3'h0);
      e = 64'h1000 + (64'h20 << w) + dext[w];
      chk(g_lin, e);
      chk(g_pc, 1);
    end
    go(KIND_MEM, SZ_DWORD, 32'h20, DISP_32, 5'h15, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h0);
    chk(g_lin, 64'h10);
    go(KIND_MEM, SZ_DWORD, 32'h0, DISP_NONE, 5'h11, 5'h14, 2'h1,
      DATA_SEGMENT_SEL, 3'h0);
    chk(g_lin, 64'h1000);
    go(KIND_MEM, SZ_DWORD, 32'h0, DISP_NONE, 5'h0, 5'h14, 2'h3,
      DATA_SEGMENT_SEL, 3'h0);
    chk(g_lin, 64'h0);
    go(KIND_MEM, SZ_DWORD, 32'h80, DISP_8, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h0);
    chk(g_lin, 64'hffffffffffffff80);
    $display("address test done");
  endtask : t_ea
  task automatic t_rel();
    go(KIND_REL, SZ_DWORD, 32'h80000000, DISP_32, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h0);
    chk(g_lin, 64'h0000123380000010);
    $display("relative test done");
  endtask : t_rel
  task automatic t_io();
    wr(PORT_INDEX_REGISTER, 64'habcd000000001233);
    go(KIND_IO, SZ_WORD, 32'hfffe, DISP_NONE, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h1);
    chk(g_lin, 64'hfffe);
    chk({bio, g_pc}, 9'h101);
    go(KIND_IO, SZ_DWORD, 32'h0, DISP_NONE, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h0);
    chk(g_lin, 64'h1233);
    chk(g_pc, 2);
    $display("port test done");
  endtask : t_io
  task automatic t_ld();
    logic [7:0] ad [6] = '{8'h03, 8'h87, 8'h84, 8'h85, 8'h88, 8'h90};
    logic [2:0] sz [6] = '{1, 1, 2, 3, 3, 0};
    logic sg [6] = '{0, 1, 0, 0, 1, 1};
    int np [6] = '{2, 2, 1, 2, 1, 1};
    for (int i = 0; i < 6; i++) begin
      lat = i[0] ? 4'h3 : 4'h0;
      go(KIND_MEM, sz[i], {24'h0, ad[i]}, DISP_32, 5'h0, 5'h0, 2'h0,
        DATA_SEGMENT_SEL, {1'b0, sg[i], 1'b0});
      chk(g_rd, ld(ad[i], sz[i], sg[i]));
      chk(g_pc, np[i]);
      chk(g_flt, 0);
    end
    $display("load test done");
  endtask : t_ld
  task automatic t_dq();
    go(KIND_MEM, SZ_DQWORD, 32'h108, DISP_32, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h4);
    chk({g_flt, g_pc}, 9'h100);
    go(KIND_MEM, SZ_DQWORD, 32'h100, DISP_32, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h4);
    chk({g_flt, g_pc}, 9'h002);
    chk(g_rd, ld(64'h100, SZ_DQWORD, 1'b0));
    go(KIND_MEM, SZ_DQWORD, 32'h104, DISP_32, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h0);
    chk({g_flt, g_pc}, 9'h003);
    chk(g_rd, ld(64'h104, SZ_DQWORD, 1'b0));
    $display("double quad test done");
  endtask : t_dq
  task automatic t_seg();
    go(KIND_MEM, SZ_DWORD, 32'h40, DISP_8, 5'h0, 5'h0, 2'h0,
      AUX_SEGMENT_SEL_A, 3'h0);
    chk(g_lin, aux_a + 64'h40);
    chk({bwe, bio}, 2'h0);
    go(KIND_MEM, SZ_DWORD, 32'h40, DISP_8, 5'h0, 5'h0, 2'h0,
      AUX_SEGMENT_SEL_B, 3'h0);
    chk(g_lin, aux_b + 64'h40);
    go(KIND_MEM, SZ_DWORD, 32'h40, DISP_8, 5'h0, 5'h0, 2'h0,
      SEG_STACK, 3'h0);
    chk(g_lin, 64'h40);
    $display("segment test done");
  endtask : t_seg
  task automatic t_st();
    logic [7:0] w0;
    w0 = wbytes;
    @(posedge mclk);
    req_write <= 1'b1;
    req_wdata <= ld(64'h86, SZ_DQWORD, 1'b0);
    go(KIND_MEM, SZ_DWORD, 32'h86, DISP_32, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h0);
    chk({bwe, bio, g_pc}, 10'h202);
    chk(8'(wbytes - w0), 4);
    @(posedge mclk);
    req_wdata <= ld(64'h10c, SZ_DQWORD, 1'b0);
    go(KIND_MEM, SZ_DQWORD, 32'h10c, DISP_32, 5'h0, 5'h0, 2'h0,
      DATA_SEGMENT_SEL, 3'h0);
    chk(g_pc, 3);
    chk(8'(wbytes - w0), 20);
    chk(wbad, 0);
    @(posedge mclk);
    req_write <= 1'b0;
    $display("store test done");
  endtask : t_st
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    {mclk, gpr_wr_en, req_valid, req_write, req_kind, req_size} = '0;
    {gpr_wr_sel, gpr_wr_data, req_disp, req_disp_width} = '0;
    {req_base_en, req_base_sel, req_index_en, req_index_sel} = '0;
    {req_scale, req_seg_sel, req_dq_strict, req_ld_signed} = '0;
    {req_io_imm_en, req_io_imm, req_wdata, lat} = '0;
    sys_rst = 1'b1;
    ce = 1'b1;
    nip = 64'h0000123400000010;
    aux_a = 64'h0000700000000000;
    aux_b = 64'h0000001000000000;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_ea();
    t_rel();
    t_io();
    t_ld();
    t_dq();
    t_st();
    t_seg();
    report_and_stop();
  end
  initial begin
    #(40 * 5000);
    n_fail++;
    report_and_stop();
  end
endmodule : tb_operand_address_alignment_unit
